// ### iopbr_pkg.sv
// constants, types and behaviour notes for the io processor bus transfer responder
// Notes on behaviour
// [RULE1] decoded status read answered with return word
// [RULE2] processor-source read followed by data write
// [RULE3] every irq control pair gets return word
// [RULE4] advance half announces; code selects action
// [RULE5] eleven distinct status read function codes
// [RULE6] identify request returns fixed identity word
// [RULE7] three irq control functions decoded
// [RULE8] ack-activate: active, memory base, dequeue
// [RULE9] ack-deactivate: drop request, base, dequeue
// [RULE10] deactivate clears active, returns plain word
// [RULE11] software ends active state by deactivate
// [RULE12] every write order pair means reset
// [RULE13] reset order always accepted, never busy
// [RULE14] reset clears all, idle, no answer
// [RULE15] status reads only to addressed controller
// [RULE16] load and allocation required after reset
// [RULE17] deactivate only for blocking-type processor
// [RULE18] uninitialised rejects non-init status reads
// [RULE19] irq request held until acknowledge or reset
`default_nettype none
package iopbr_pkg;
    // transfer kinds on the shared bus
    typedef enum logic [2:0] {
        IOPBR_K_NONE,
        IOPBR_K_ADV_STAT,
        IOPBR_K_STAT,
        IOPBR_K_ADV_IRQ,
        IOPBR_K_IRQ,
        IOPBR_K_WORDER,
        IOPBR_K_WDATA
    } iopbr_kind_e;
    localparam int unsigned IOPBR_DW = 32;
    localparam int unsigned IOPBR_AW = 24;
    localparam int unsigned IOPBR_DEST_W = 4;
    // function code sits in the top byte of the data word
    localparam int unsigned IOPBR_CODE_HI = 31;
    localparam int unsigned IOPBR_CODE_LO = 24;
    localparam logic [7:0] IOPBR_NUM_STAT_FUNCS = 8'h0B;
    // status read function codes
    localparam logic [7:0] IOPBR_F_IDENTIFY = 8'h00;
    localparam logic [7:0] IOPBR_F_LOAD_CTRL_MEM = 8'h01;
    localparam logic [7:0] IOPBR_F_MEM_ALLOC = 8'h02;
    localparam logic [7:0] IOPBR_F_IRQ_ENABLE = 8'h03;
    localparam logic [7:0] IOPBR_F_IRQ_DISABLE = 8'h04;
    localparam logic [7:0] IOPBR_F_READ_CPU_SRC = 8'h05;
    // irq control function codes
    localparam logic [7:0] IOPBR_I_ACK_ACTIVATE = 8'h01;
    localparam logic [7:0] IOPBR_I_ACK_DEACTIVATE = 8'h02;
    localparam logic [7:0] IOPBR_I_DEACTIVATE = 8'h03;
    // return word fields
    localparam int unsigned IOPBR_RET_ACCEPT_BIT = 31;
    localparam int unsigned IOPBR_RET_REJECT_BIT = 30;
    localparam int unsigned IOPBR_RET_ACTIVE_BIT = 29;
    localparam logic [7:0] IOPBR_RET_PAD = 8'h00;
    localparam logic [31:0] IOPBR_ZERO_WORD = 32'h0000_0000;
    localparam logic [23:0] IOPBR_ZERO_ADDR = 24'h00_0000;
    localparam logic [7:0] IOPBR_ZERO_CODE = 8'h00;
    // identity word, value arbitrary
    localparam logic [31:0] IOPBR_IDENTITY_WORD = 32'h0F5A_0001;
    // this controller's bus address, value arbitrary
    localparam logic [3:0] IOPBR_DEV_ADDR = 4'h3;
endpackage
`default_nettype wire

// ### iopbr_bus_if.sv
// bus carrier joining the processor end and the io processor end
`timescale 1ns/1ps
`default_nettype none
interface iopbr_bus_if (
    input wire logic sys_clk,
    input wire logic rst_b
);
    logic xfer_valid;
    iopbr_pkg::iopbr_kind_e xfer_kind;
    logic [3:0] xfer_dest;
    logic [31:0] xfer_data;
    logic ret_valid;
    logic [31:0] ret_data;
    logic xfer_busy;

    modport dev (
        input sys_clk, rst_b, xfer_valid, xfer_kind, xfer_dest, xfer_data,
        output ret_valid, ret_data, xfer_busy
    );
    modport host (
        input sys_clk, rst_b, ret_valid, ret_data, xfer_busy,
        output xfer_valid, xfer_kind, xfer_dest, xfer_data
    );
endinterface
`default_nettype wire

// ### iopbr_device.sv
// io processor end: decodes transfer pairs and answers status and irq control pairs; write orders get no answer
`timescale 1ns/1ps
`default_nettype none
module iopbr_device (
    iopbr_bus_if.dev bus,
    input wire logic io_done,
    output logic irq_request,
    output logic irq_active,
    output logic irq_enable,
    output logic initialised,
    output logic func_valid,
    output logic [7:0] func_code,
    output logic [23:0] func_arg,
    output logic wdata_valid,
    output logic [31:0] wdata,
    output logic [23:0] mem_base,
    output logic status_posted
);
    typedef struct packed {
        logic adv_stat;
        logic adv_irq;
        logic [7:0] adv_code;
        logic ctrl_loaded;
        logic mem_alloc;
        logic [23:0] mem_base;
        logic irq_enable;
        logic irq_request;
        logic irq_active;
        logic status_posted;
        logic ret_valid;
        logic [31:0] ret_data;
        logic func_valid;
        logic [7:0] func_code;
        logic [23:0] func_arg;
        logic wdata_valid;
        logic [31:0] wdata;
    } iopbr_dev_s;

    iopbr_dev_s st;
    iopbr_dev_s next_st;

    // top byte of a data word
    function automatic logic [7:0] iopbr_code(input logic [31:0] w);
        iopbr_code = w[iopbr_pkg::IOPBR_CODE_HI:iopbr_pkg::IOPBR_CODE_LO];
    endfunction

    // return word with accept, reject and active flags plus the address, or the echoed code when the address is zero
    function automatic logic [31:0] iopbr_ret(input logic acc, input logic act,
                                              input logic [7:0] code,
                                              input logic [23:0] addr);
        logic [31:0] w;
        w = {iopbr_pkg::IOPBR_RET_PAD, addr};
        if (addr == iopbr_pkg::IOPBR_ZERO_ADDR) begin
            w = {iopbr_pkg::IOPBR_RET_PAD, 16'h0000, code};
        end
        w[iopbr_pkg::IOPBR_RET_ACCEPT_BIT] = acc;
        w[iopbr_pkg::IOPBR_RET_REJECT_BIT] = ~acc;
        w[iopbr_pkg::IOPBR_RET_ACTIVE_BIT] = act;
        iopbr_ret = w;
    endfunction

    logic hit;
    logic [7:0] code;
    logic is_init_func;
    logic can_run;

    assign hit = bus.xfer_valid && (bus.xfer_dest == iopbr_pkg::IOPBR_DEV_ADDR);
    assign code = iopbr_code(bus.xfer_data);
    assign is_init_func = (code == iopbr_pkg::IOPBR_F_IDENTIFY)
                       || (code == iopbr_pkg::IOPBR_F_LOAD_CTRL_MEM)
                       || (code == iopbr_pkg::IOPBR_F_MEM_ALLOC);
    // init functions run always; the rest only once initialised
    assign can_run = (code < iopbr_pkg::IOPBR_NUM_STAT_FUNCS)
                  && (is_init_func || (st.ctrl_loaded && st.mem_alloc));

    // next state: one-cycle pulses drop, then decode the taken transfer
    always_comb begin
        next_st = st;
        next_st.ret_valid = 1'b0;
        next_st.func_valid = 1'b0;
        next_st.wdata_valid = 1'b0;
        if (hit) begin
            case (bus.xfer_kind)
                iopbr_pkg::IOPBR_K_ADV_STAT: begin
                    // [RULE4] advance latches code
                    next_st.adv_stat = 1'b1;
                    next_st.adv_irq = 1'b0;
                    next_st.adv_code = code;
                end
                iopbr_pkg::IOPBR_K_ADV_IRQ: begin
                    // [RULE4] advance latches code
                    next_st.adv_irq = 1'b1;
                    next_st.adv_stat = 1'b0;
                    next_st.adv_code = code;
                end
                iopbr_pkg::IOPBR_K_STAT: begin
                    next_st.adv_stat = 1'b0;
                    // [RULE1] always answer status read
                    next_st.ret_valid = 1'b1;
                    if (!st.adv_stat || st.adv_code != code) begin
                        // unannounced main half is refused
                        next_st.ret_data = iopbr_ret(1'b0, st.irq_active, code,
                                                     iopbr_pkg::IOPBR_ZERO_ADDR);
                    end else if (code == iopbr_pkg::IOPBR_F_IDENTIFY) begin
                        // [RULE6] fixed identity answer
                        next_st.ret_data = iopbr_pkg::IOPBR_IDENTITY_WORD;
                    end else if (!can_run) begin
                        // [RULE18] reject while uninitialised
                        // [RULE5] codes from eleven up rejected
                        next_st.ret_data = iopbr_ret(1'b0, st.irq_active, code,
                                                     iopbr_pkg::IOPBR_ZERO_ADDR);
                    end else begin
                        next_st.ret_data = iopbr_ret(1'b1, st.irq_active, code,
                                                     iopbr_pkg::IOPBR_ZERO_ADDR);
                        // [RULE5] per-function actions
                        case (code)
                            iopbr_pkg::IOPBR_F_LOAD_CTRL_MEM: next_st.ctrl_loaded = 1'b1;
                            iopbr_pkg::IOPBR_F_MEM_ALLOC: begin
                                next_st.mem_alloc = 1'b1;
                                next_st.mem_base = bus.xfer_data[23:0];
                            end
                            iopbr_pkg::IOPBR_F_IRQ_ENABLE: next_st.irq_enable = 1'b1;
                            iopbr_pkg::IOPBR_F_IRQ_DISABLE: next_st.irq_enable = 1'b0;
                            default: begin
                            end
                        endcase
                        // accepted functions are passed on to panel logic
                        next_st.func_valid = 1'b1;
                        next_st.func_code = code;
                        next_st.func_arg = bus.xfer_data[23:0];
                    end
                end
                iopbr_pkg::IOPBR_K_IRQ: begin
                    next_st.adv_irq = 1'b0;
                    // [RULE3] always answer irq control
                    next_st.ret_valid = 1'b1;
                    next_st.ret_data = iopbr_ret(1'b0, st.irq_active, code,
                                                 iopbr_pkg::IOPBR_ZERO_ADDR);
                    if (st.adv_irq && st.adv_code == code) begin
                        // [RULE7] three irq functions
                        case (code)
                            iopbr_pkg::IOPBR_I_ACK_ACTIVATE: begin
                                // [RULE8] go active, dequeue
                                next_st.irq_active = 1'b1;
                                next_st.irq_request = 1'b0;
                                next_st.status_posted = 1'b0;
                                next_st.ret_data = iopbr_ret(1'b1, 1'b1, code,
                                                             st.mem_base);
                            end
                            iopbr_pkg::IOPBR_I_ACK_DEACTIVATE: begin
                                // [RULE9] drop request, dequeue
                                next_st.irq_request = 1'b0;
                                next_st.status_posted = 1'b0;
                                next_st.ret_data = iopbr_ret(1'b1, st.irq_active, code,
                                                             st.mem_base);
                            end
                            iopbr_pkg::IOPBR_I_DEACTIVATE: begin
                                // [RULE10] clear active state
                                // [RULE11] active held until here
                                next_st.irq_active = 1'b0;
                                next_st.ret_data = iopbr_ret(1'b1, 1'b0, code,
                                                             iopbr_pkg::IOPBR_ZERO_ADDR);
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                iopbr_pkg::IOPBR_K_WORDER: begin
                    // [RULE12] any write order resets
                    // [RULE14] clear all, no answer
                    next_st = '0;
                end
                iopbr_pkg::IOPBR_K_WDATA: begin
                    // [RULE2] processor-sourced data to panel
                    next_st.wdata_valid = 1'b1;
                    next_st.wdata = bus.xfer_data;
                end
                default: begin
                end
            endcase
        end
        // [RULE19] request held; a new event wins over the clear
        if (io_done && st.irq_enable && next_st.irq_enable) begin
            next_st.irq_request = 1'b1;
            next_st.status_posted = 1'b1;
        end
    end

    // state register
    always_ff @(posedge bus.sys_clk or negedge bus.rst_b) begin
        if (!bus.rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // [RULE13] never busy, so the reset order is always taken
    assign bus.xfer_busy = 1'b0;
    assign bus.ret_valid = st.ret_valid;
    assign bus.ret_data = st.ret_data;
    assign irq_request = st.irq_request;
    assign irq_active = st.irq_active;
    assign irq_enable = st.irq_enable;
    assign initialised = st.ctrl_loaded && st.mem_alloc;
    assign func_valid = st.func_valid;
    assign func_code = st.func_code;
    assign func_arg = st.func_arg;
    assign wdata_valid = st.wdata_valid;
    assign wdata = st.wdata;
    assign mem_base = st.mem_base;
    assign status_posted = st.status_posted;
endmodule
`default_nettype wire

// ### iopbr_host.sv
// processor end: issues transfer pairs and collects return words
`timescale 1ns/1ps
`default_nettype none
module iopbr_host (
    iopbr_bus_if.host bus,
    input wire logic cmd_valid,
    input wire iopbr_pkg::iopbr_kind_e cmd_kind,
    input wire logic [7:0] cmd_code,
    input wire logic [23:0] cmd_arg,
    input wire logic [31:0] cmd_wdata,
    input wire logic blocking_cfg,
    output logic cmd_ready,
    output logic resp_valid,
    output logic resp_err,
    output logic [31:0] resp_data,
    output logic needs_init
);
    typedef enum logic [2:0] {
        IOPBR_H_IDLE,
        IOPBR_H_ADV,
        IOPBR_H_MAIN,
        IOPBR_H_WAIT,
        IOPBR_H_WDATA
    } iopbr_hstate_e;

    typedef struct packed {
        iopbr_hstate_e state;
        iopbr_pkg::iopbr_kind_e kind;
        logic [31:0] word;
        logic [31:0] wdata;
        logic resp_valid;
        logic resp_err;
        logic [31:0] resp_data;
        logic loaded;
        logic allocated;
    } iopbr_host_s;

    iopbr_host_s st;
    iopbr_host_s next_st;
    logic illegal;

    // [RULE17] deactivate only to blocking type
    // [RULE16] only init reads until initialised
    assign illegal = (cmd_kind == iopbr_pkg::IOPBR_K_IRQ
                      && cmd_code == iopbr_pkg::IOPBR_I_DEACTIVATE && !blocking_cfg)
                  || (cmd_kind == iopbr_pkg::IOPBR_K_STAT && !(st.loaded && st.allocated)
                      && cmd_code > iopbr_pkg::IOPBR_F_MEM_ALLOC);

    // sequencing of one pair per command
    always_comb begin
        next_st = st;
        next_st.resp_valid = 1'b0;
        case (st.state)
            IOPBR_H_IDLE: begin
                if (cmd_valid) begin
                    next_st.kind = cmd_kind;
                    next_st.word = {cmd_code, cmd_arg};
                    next_st.wdata = cmd_wdata;
                    if (illegal) begin
                        next_st.resp_valid = 1'b1;
                        next_st.resp_err = 1'b1;
                        next_st.resp_data = iopbr_pkg::IOPBR_ZERO_WORD;
                    end else begin
                        next_st.state = IOPBR_H_ADV;
                    end
                end
            end
            IOPBR_H_ADV: begin
                next_st.state = IOPBR_H_MAIN;
            end
            IOPBR_H_MAIN: begin
                if (st.kind == iopbr_pkg::IOPBR_K_WORDER) begin
                    // reset order has no answer; init needed again
                    next_st.state = IOPBR_H_IDLE;
                    next_st.loaded = 1'b0;
                    next_st.allocated = 1'b0;
                    next_st.resp_valid = 1'b1;
                    next_st.resp_err = 1'b0;
                    next_st.resp_data = iopbr_pkg::IOPBR_ZERO_WORD;
                end else begin
                    next_st.state = IOPBR_H_WAIT;
                end
            end
            IOPBR_H_WAIT: begin
                if (bus.ret_valid) begin
                    next_st.resp_valid = 1'b1;
                    next_st.resp_data = bus.ret_data;
                    next_st.resp_err = (st.kind == iopbr_pkg::IOPBR_K_STAT)
                        && (st.word[31:24] != iopbr_pkg::IOPBR_F_IDENTIFY)
                        && !bus.ret_data[iopbr_pkg::IOPBR_RET_ACCEPT_BIT];
                    next_st.state = IOPBR_H_IDLE;
                    if (st.kind == iopbr_pkg::IOPBR_K_STAT
                        && bus.ret_data[iopbr_pkg::IOPBR_RET_ACCEPT_BIT]) begin
                        if (st.word[31:24] == iopbr_pkg::IOPBR_F_LOAD_CTRL_MEM) begin
                            next_st.loaded = 1'b1;
                        end
                        if (st.word[31:24] == iopbr_pkg::IOPBR_F_MEM_ALLOC) begin
                            next_st.allocated = 1'b1;
                        end
                        // [RULE2] follow with data write
                        if (st.word[31:24] == iopbr_pkg::IOPBR_F_READ_CPU_SRC) begin
                            next_st.state = IOPBR_H_WDATA;
                        end
                    end
                end
            end
            IOPBR_H_WDATA: begin
                next_st.state = IOPBR_H_IDLE;
            end
            default: begin
                next_st.state = IOPBR_H_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge bus.sys_clk or negedge bus.rst_b) begin
        if (!bus.rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // bus drive; [RULE15] always the single device address
    always_comb begin
        bus.xfer_valid = 1'b0;
        bus.xfer_kind = iopbr_pkg::IOPBR_K_NONE;
        bus.xfer_dest = iopbr_pkg::IOPBR_DEV_ADDR;
        bus.xfer_data = st.word;
        case (st.state)
            IOPBR_H_ADV: begin
                bus.xfer_valid = 1'b1;
                if (st.kind == iopbr_pkg::IOPBR_K_STAT) begin
                    bus.xfer_kind = iopbr_pkg::IOPBR_K_ADV_STAT;
                end else if (st.kind == iopbr_pkg::IOPBR_K_IRQ) begin
                    bus.xfer_kind = iopbr_pkg::IOPBR_K_ADV_IRQ;
                end else begin
                    bus.xfer_kind = iopbr_pkg::IOPBR_K_WORDER;
                end
            end
            IOPBR_H_MAIN: begin
                bus.xfer_valid = 1'b1;
                bus.xfer_kind = st.kind;
            end
            IOPBR_H_WDATA: begin
                bus.xfer_valid = 1'b1;
                bus.xfer_kind = iopbr_pkg::IOPBR_K_WDATA;
                bus.xfer_data = st.wdata;
            end
            default: begin
            end
        endcase
    end

    assign cmd_ready = (st.state == IOPBR_H_IDLE);
    assign resp_valid = st.resp_valid;
    assign resp_err = st.resp_err;
    assign resp_data = st.resp_data;
    assign needs_init = !(st.loaded && st.allocated);
endmodule
`default_nettype wire

// ### iopbr_assertions.sv
// concurrent checks on the bus joining the processor end and the io processor end
`timescale 1ns/1ps
`default_nettype none
module iopbr_assertions (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic xfer_valid,
    input wire iopbr_pkg::iopbr_kind_e xfer_kind,
    input wire logic [3:0] xfer_dest,
    input wire logic [31:0] xfer_data,
    input wire logic ret_valid,
    input wire logic [31:0] ret_data,
    input wire logic xfer_busy
);
    logic take;
    logic [7:0] code;
    logic adv_s, main_s, adv_i, main_i, worder;
    // decode once so the properties stay short; only our address counts
    assign take = xfer_valid && (xfer_dest == iopbr_pkg::IOPBR_DEV_ADDR);
    assign code = xfer_data[31:24];
    assign adv_s = take && (xfer_kind == iopbr_pkg::IOPBR_K_ADV_STAT);
    assign main_s = take && (xfer_kind == iopbr_pkg::IOPBR_K_STAT);
    assign adv_i = take && (xfer_kind == iopbr_pkg::IOPBR_K_ADV_IRQ);
    assign main_i = take && (xfer_kind == iopbr_pkg::IOPBR_K_IRQ);
    assign worder = take && (xfer_kind == iopbr_pkg::IOPBR_K_WORDER);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_stat_answered: assert property (
        main_s |=> ret_valid) else $error("status read got no return word");
    a_irq_answered: assert property (
        main_i |=> ret_valid) else $error("irq control pair got no return word");
    a_advance_silent: assert property (
        adv_s || adv_i |=> !ret_valid) else $error("advance half was answered");
    a_answer_has_cause: assert property (
        ret_valid |-> $past(main_s || main_i)) else $error("return word without main half");
    a_reset_silent: assert property (
        worder |=> !ret_valid [*2]) else $error("reset order produced a return word");
    a_never_busy: assert property (
        !xfer_busy) else $error("device signalled busy");
    a_identify_word: assert property (
        adv_s && code == 8'h00 ##1 main_s && code == 8'h00
        |=> ret_data == iopbr_pkg::IOPBR_IDENTITY_WORD) else $error("identify word wrong");
    a_code_range: assert property (
        adv_s && code >= 8'h0B ##1 main_s && code >= 8'h0B
        |=> ret_data[31:30] == 2'h1) else $error("out of range code not rejected");
    a_activate_sets: assert property (
        adv_i && code == 8'h01 ##1 main_i && code == 8'h01
        |=> ret_data[31] && ret_data[29]) else $error("ack activate left irq inactive");
    a_deactivate_clears: assert property (
        adv_i && code == 8'h03 ##1 main_i && code == 8'h03
        |=> !ret_data[29]) else $error("deactivate left irq active");
endmodule
`default_nettype wire

// ### tb_io_processor_bus_transfer_responder.sv
// self-checking bench: processor end and io processor end joined on one bus
`timescale 1ns/1ps
`default_nettype none
module tb_io_processor_bus_transfer_responder;
    logic sys_clk, rst_b, io_done, cmd_valid, blocking_cfg, cmd_ready, resp_valid, resp_err;
    logic irq_request, irq_active, irq_enable, initialised, wdata_valid, status_posted;
    logic needs_init, got_err, func_valid;
    logic [7:0] cmd_code, func_code;
    logic [23:0] cmd_arg, mem_base, func_arg;
    logic [31:0] cmd_wdata, wdata, resp_data, got, got_w, got_f;
    iopbr_pkg::iopbr_kind_e cmd_kind;
    int fails, comparisons;
    iopbr_bus_if u_iopbr_bus_if (.sys_clk(sys_clk), .rst_b(rst_b));
    iopbr_device u_iopbr_device (.bus(u_iopbr_bus_if), .io_done(io_done),
        .irq_request(irq_request), .irq_active(irq_active), .irq_enable(irq_enable),
        .initialised(initialised), .func_valid(func_valid), .func_code(func_code),
        .func_arg(func_arg),
        .wdata_valid(wdata_valid), .wdata(wdata), .mem_base(mem_base),
        .status_posted(status_posted));
    iopbr_host u_iopbr_host (.bus(u_iopbr_bus_if), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_wdata(cmd_wdata),
        .blocking_cfg(blocking_cfg), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_err(resp_err), .resp_data(resp_data), .needs_init(needs_init));
    iopbr_assertions u_iopbr_assertions (.sys_clk(sys_clk), .rst_b(rst_b),
        .xfer_valid(u_iopbr_bus_if.xfer_valid), .xfer_kind(u_iopbr_bus_if.xfer_kind),
        .xfer_dest(u_iopbr_bus_if.xfer_dest), .xfer_data(u_iopbr_bus_if.xfer_data),
        .ret_valid(u_iopbr_bus_if.ret_valid), .ret_data(u_iopbr_bus_if.ret_data),
        .xfer_busy(u_iopbr_bus_if.xfer_busy));
    // free-running system clock
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    // keep words handed to panel logic
    always @(posedge sys_clk) begin
        if (wdata_valid === 1'h1) got_w <= wdata;
        if (func_valid === 1'h1) got_f <= {func_code, func_arg};
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one command; answer within 20 cycles
    task automatic send(input iopbr_pkg::iopbr_kind_e kind, input logic [7:0] code,
        input logic [23:0] arg);
        int n;
        cmd_kind = kind;
        cmd_code = code;
        cmd_arg = arg;
        cmd_valid = 1'h1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        cmd_valid = 1'h0;
        n = 0;
        while (resp_valid !== 1'h1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 20) chk("resp_valid", 32'h1, 32'h0);
        got = resp_data;
        got_err = resp_err;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic pulse_done();
        io_done = 1'h1;
        @(negedge sys_clk);
        io_done = 1'h0;
        @(negedge sys_clk);
    endtask
    task automatic t_bring_up();
        chk("needs_init", 32'h1, needs_init);
        chk("cmd_ready", 32'h1, cmd_ready);
        send(iopbr_pkg::IOPBR_K_STAT, 8'h03, 24'h0);
        chk("uninit refusal", 32'h1, got_err);
        send(iopbr_pkg::IOPBR_K_STAT, 8'h00, 24'h0);
        chk("identity", iopbr_pkg::IOPBR_IDENTITY_WORD, got);
        send(iopbr_pkg::IOPBR_K_STAT, 8'h01, 24'h0);
        send(iopbr_pkg::IOPBR_K_STAT, 8'h02, 24'h5A_5A00);
        chk("alloc accept", 32'h1, got[31]);
        chk("initialised", 32'h1, initialised);
        chk("mem_base", 32'h5A_5A00, mem_base);
    endtask
    // codes from 3 up, then two out of range
    task automatic t_status_codes();
        for (int c = 3; c < 11; c++) begin
            cmd_wdata = 32'hC0DE_0000 | c;
            send(iopbr_pkg::IOPBR_K_STAT, c[7:0], 24'h0);
            chk("status word", {3'h4, 16'h0, c[7:0]}, {got[31:29], got[23:0]});
            chk("func word", {c[7:0], 24'h0}, got_f);
            if (c == 5) chk("cpu source data", cmd_wdata, got_w);
            if (c == 3 || c == 4) chk("irq_enable", c == 3, irq_enable);
        end
        send(iopbr_pkg::IOPBR_K_STAT, 8'h0B, 24'h0);
        chk("reject 0B", 32'h1, got[31:30]);
        send(iopbr_pkg::IOPBR_K_STAT, 8'hFF, 24'h0);
        chk("reject FF", 32'h1, got[31:30]);
    endtask
    task automatic t_irq_flow();
        send(iopbr_pkg::IOPBR_K_STAT, 8'h03, 24'h0);
        pulse_done();
        chk("irq_request", 32'h1, irq_request);
        chk("status_posted", 32'h1, status_posted);
        send(iopbr_pkg::IOPBR_K_IRQ, 8'h00, 24'h0);
        chk("unknown irq code", 32'h0, got[31]);
        chk("request held", 32'h1, irq_request);
        send(iopbr_pkg::IOPBR_K_IRQ, 8'h01, 24'h0);
        chk("activate word", {3'h5, 24'h5A_5A00}, {got[31:29], got[23:0]});
        chk("active", 32'h4, {irq_active, irq_request, status_posted});
        blocking_cfg = 1'h0;
        send(iopbr_pkg::IOPBR_K_IRQ, 8'h03, 24'h0);
        chk("nonblocking refusal", 32'h1, got_err);
        chk("still active", 32'h1, irq_active);
        blocking_cfg = 1'h1;
        send(iopbr_pkg::IOPBR_K_IRQ, 8'h03, 24'h0);
        chk("deactivate word", 32'h0, got[29]);
        chk("inactive", 32'h0, irq_active);
        pulse_done();
        send(iopbr_pkg::IOPBR_K_IRQ, 8'h02, 24'h0);
        chk("ack deactivate word", {3'h4, 24'h5A_5A00}, {got[31:29], got[23:0]});
        chk("request dropped", 32'h0, {irq_request, irq_active, status_posted});
    endtask
    // reset order with a stray code
    task automatic t_reset_order();
        pulse_done();
        send(iopbr_pkg::IOPBR_K_WORDER, 8'hAB, 24'h0);
        chk("reset accepted", 32'h0, got_err);
        chk("reset cleared", 32'h0, {irq_request, irq_enable, initialised, mem_base});
        chk("needs_init", 32'h1, needs_init);
        send(iopbr_pkg::IOPBR_K_STAT, 8'h00, 24'h0);
        chk("identity after reset", iopbr_pkg::IOPBR_IDENTITY_WORD, got);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // run needs under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        wrap_up();
    end
    initial begin
        {rst_b, io_done, cmd_valid, cmd_code, cmd_arg, cmd_wdata} = '0;
        blocking_cfg = 1'h1;
        cmd_kind = iopbr_pkg::IOPBR_K_NONE;
        repeat (20) @(negedge sys_clk);
        rst_b = 1'h1;
        t_bring_up();
        t_status_codes();
        t_irq_flow();
        t_reset_order();
        wrap_up();
    end
endmodule
`default_nettype wire
